// File: sim/adc_self_calibration_tb.sv
// self-checking bench: registers, compensation and calibration control
`default_nettype none
module adc_self_calibration_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int cal = 20;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic        stop_mode = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [3:0]  wsel = 4'hf;
    logic [7:0]  ta;
    logic [31:0] dat_o;
    logic        ack;
    logic        calibrating;
    int          bad_count = 0;
    int          n_checks = 0;
    int          ticks = 0;
    int          seed = 69973;
    int          pg, mg, off, raw, n, i, k, sum, msum, t;
    longint      ex;
    always #5 sys_clk = ~sys_clk;
    adcsc_top #(.cal_cycles(cal)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .stop_mode(stop_mode),
        .calibrating(calibrating));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // one classic bus cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge sys_clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= wsel;
        do @(posedge sys_clk); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, rdat, e);
    endtask : rd
    // wait for the calibrating level, counting cycles spent
    task automatic wait_cal(input logic v);
        n = 0;
        while (calibrating !== v && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        chk("calibrating", calibrating, v);
    endtask : wait_cal
    // cuts a hang short
    always @(posedge sys_clk) begin
        ticks++;
        if (ticks == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(adcsc_pkg::pgain_off, 32'h8310, "pgain_reset");
        rd(adcsc_pkg::mgain_off, 32'h8310, "mgain_reset");
        rd(adcsc_pkg::offset_off, 32'h0, "offset_reset");
        wb(1'b1, 8'h80, 32'h1234);
        rd(8'h80, 32'h0, "unmapped");
        // random conversions, single-ended and differential
        for (k = 0; k < 8; k++) begin
            pg  = 32'h8000 + ($random(seed) & 32'h3ff);
            mg  = 32'h8000 + ($random(seed) & 32'h3ff);
            off = ($random(seed) % 4096) & 32'hffff;
            raw = $random(seed) & 32'hffff;
            wb(1'b1, adcsc_pkg::pgain_off, pg);
            wb(1'b1, adcsc_pkg::mgain_off, mg);
            wb(1'b1, adcsc_pkg::offset_off, off);
            rd(adcsc_pkg::offset_off, off, "offset_rw");
            wb(1'b1, adcsc_pkg::raw_off, raw);
            wb(1'b1, adcsc_pkg::ctrl_off, 32'h100 | (k[0] << 7));
            ex = longint'(raw) - longint'($signed(off[15:0]));
            if (ex < 0) ex = 0;
            ex = (ex * (k[0] ? mg : pg)) >> 15;
            if (ex > 65535) ex = 65535;
            i = 0;
            do begin
                wb(1'b0, adcsc_pkg::result_off, 32'h0);
                i++;
            end while (rdat !== ex[31:0] && i < 10);
            chk("result", rdat, ex[31:0]);
        end
        // low byte lane only: the upper offset byte must stay
        wsel = 4'h1;
        wb(1'b1, adcsc_pkg::offset_off, 32'habcd);
        wsel = 4'hf;
        off = (off & 32'hff00) | 32'hcd;
        rd(adcsc_pkg::offset_off, off, "offset_lane");
        // calibration with high speed and 32-sample averaging
        wb(1'b1, adcsc_pkg::ctrl_off, 32'h79);
        wait_cal(1'b1);
        wait_cal(1'b0);
        chk("cal_budget", n <= cal, 1'b1);
        rd(adcsc_pkg::stat_off, 32'h1, "stat_done");
        // restore trim outputs by writes, then derive both gains
        sum  = 0;
        msum = 0;
        for (i = 0; i < 12; i++) begin
            t  = $random(seed) & 32'hffff;
            ta = (i < 6) ? adcsc_pkg::ptrim_off + 8'(4 * i)
                         : adcsc_pkg::mtrim_off + 8'(4 * (i - 6));
            wb(1'b1, ta, t);
            rd(ta, t, "trim_rw");
            if (i < 6) sum += t;
            else msum += t;
        end
        pg = ((sum & 32'hffff) >> 1) | 32'h8000;
        mg = ((msum & 32'hffff) >> 1) | 32'h8000;
        wb(1'b1, adcsc_pkg::pgain_off, pg);
        wb(1'b1, adcsc_pkg::mgain_off, mg);
        rd(adcsc_pkg::pgain_off, pg, "pgain_derived");
        rd(adcsc_pkg::mgain_off, mg, "mgain_derived");
        // start bit written again while set: no new run
        wb(1'b1, adcsc_pkg::ctrl_off, 32'h79);
        repeat (4) begin
            @(posedge sys_clk);
            chk("no_restart", calibrating, 1'b0);
        end
        // start with hardware trigger selected is refused
        wb(1'b1, adcsc_pkg::ctrl_off, 32'h78);
        wb(1'b1, adcsc_pkg::ctrl_off, 32'h7b);
        wb(1'b0, adcsc_pkg::stat_off, 32'h0);
        chk("stat_hw_fail", rdat & 32'h6, 32'h2);
        rd(adcsc_pkg::ctrl_off, 32'h7a, "ctrl_hw_fail");
        // fresh start clears status; a write then aborts the run
        wb(1'b1, adcsc_pkg::ctrl_off, 32'h78);
        wb(1'b1, adcsc_pkg::ctrl_off, 32'h79);
        wait_cal(1'b1);
        rd(adcsc_pkg::stat_off, 32'h4, "stat_restart");
        wb(1'b1, adcsc_pkg::pgain_off, pg ^ 32'h1);
        wait_cal(1'b0);
        wb(1'b0, adcsc_pkg::stat_off, 32'h0);
        chk("stat_wr_fail", rdat & 32'h6, 32'h2);
        rd(adcsc_pkg::pgain_off, pg, "pgain_kept");
        rd(adcsc_pkg::ctrl_off, 32'h78, "ctrl_wr_fail");
        // stop mode in mid-run aborts it
        wb(1'b1, adcsc_pkg::ctrl_off, 32'h79);
        wait_cal(1'b1);
        stop_mode <= 1'b1;
        wait_cal(1'b0);
        stop_mode <= 1'b0;
        wb(1'b0, adcsc_pkg::stat_off, 32'h0);
        chk("stat_stop_fail", rdat & 32'h6, 32'h2);
        rd(adcsc_pkg::ctrl_off, 32'h78, "ctrl_stop_fail");
        finish_test();
    end
endmodule : adc_self_calibration_tb
`default_nettype wire

// File: sim/adcsc_assertions.sv
// checker for bus handshake and calibration control at the top ports
`default_nettype none
module adcsc_chk #(
    parameter int cal_cycles = 20
) (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        stop_mode,
    input wire logic        calibrating
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // request taken at this edge, and start writes to the control register
    logic req;
    logic cal_wr;
    logic cal_ok;
    int   run_d;
    int   run_q;
    assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign cal_wr = req && wb_we_i && wb_adr_i == adcsc_pkg::ctrl_off
                    && wb_dat_i[0];
    assign cal_ok = cal_wr && !wb_dat_i[1];
    // length of the current calibration run
    always_comb run_d = calibrating ? run_q + 1 : 0;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) run_q <= 0;
        else run_q <= run_d;
    end
    sequence s_write_running;
        calibrating && req && wb_we_i;
    endsequence
    sequence s_idle_four;
        !calibrating [*4];
    endsequence
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_next: assert property (req |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");
    a_upper_zero: assert property (wb_ack_o && !wb_we_i
        |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_start_cause: assert property ($rose(calibrating) |->
        $past(cal_ok, 1) || $past(cal_ok, 2) || $past(cal_ok, 3)
        || $past(cal_ok, 4))
        else $error("calibration started without a start write");
    a_hw_refused: assert property (
        cal_wr && wb_dat_i[1] && !calibrating |=> s_idle_four)
        else $error("calibration started with hardware trigger");
    a_write_abort: assert property (
        s_write_running |-> ##[1:4] !calibrating)
        else $error("write during calibration did not abort it");
    a_stop_abort: assert property (
        calibrating && stop_mode |-> ##[1:5] !calibrating)
        else $error("stop mode did not abort calibration");
    a_cal_budget: assert property (run_q <= cal_cycles)
        else $error("calibration ran past its cycle budget");
endmodule : adcsc_chk
bind adcsc_top adcsc_chk #(.cal_cycles(cal_cycles)) u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .stop_mode(stop_mode),
    .calibrating(calibrating));
`default_nettype wire

// File: src/adcsc_comp.sv
// offset and gain compensation of a raw conversion result
`default_nettype none
module adcsc_comp (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        go,
    input  wire logic [15:0] raw,
    input  wire logic        negative,
    input  wire logic [15:0] offset,
    input  wire logic [15:0] pgain,
    input  wire logic [15:0] mgain,
    output logic [15:0]      result,
    output logic             valid
);
    logic signed [17:0] sub_v;
    logic        [17:0] mag_v;
    logic        [33:0] prod_v;
    logic        [15:0] result_d;
    logic        [15:0] result_q;
    logic               valid_q;

    // offset is left-justified two's complement: subtract first, then scale
    always_comb begin
        sub_v = $signed({2'b00, raw}) - 18'($signed(offset));
        mag_v = sub_v[17] ? 18'h00000 : 18'(sub_v);
        prod_v = 34'(mag_v) * 34'(negative ? mgain : pgain);
        result_d = result_q;
        if (go) begin
            result_d = (|prod_v[33:31]) ? 16'hffff : prod_v[30:15];
        end
    end

    // register the compensated value into the result
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            result_q <= 16'h0000;
            valid_q  <= 1'b0;
        end else begin
            result_q <= result_d;
            valid_q  <= go;
        end
    end

    assign result = result_q;
    assign valid  = valid_q;
endmodule : adcsc_comp
`default_nettype wire

// File: src/adcsc_pkg.sv
// package for adc self calibration control: offsets, fields, resets, timing
`default_nettype none
package adcsc_pkg;
    // register byte offsets (word aligned)
    localparam logic [7:0] ctrl_off      = 8'h00; // control bits
    localparam logic [7:0] stat_off      = 8'h04; // status flags
    localparam logic [7:0] offset_off    = 8'h08; // offset compensation
    localparam logic [7:0] pgain_off     = 8'h0c; // plus_side_gain
    localparam logic [7:0] mgain_off     = 8'h10; // minus_side_gain
    localparam logic [7:0] ptrim_off     = 8'h14; // plus_trim_out_0..s
    localparam logic [7:0] mtrim_off     = 8'h2c; // minus_trim_out_0..s
    localparam logic [7:0] result_off    = 8'h44; // compensated result
    localparam logic [7:0] raw_off       = 8'h48; // raw input for tests
    localparam int         trim_count    = 6;
    // control register field positions
    localparam int ctrl_cal_bit    = 0;  // calibration start
    localparam int ctrl_trig_bit   = 1;  // hw_trigger_select
    localparam int ctrl_lp_bit     = 2;  // low_power_select
    localparam int ctrl_hs_bit     = 3;  // high_speed_select
    localparam int ctrl_avg_bit    = 4;  // averaging_on
    localparam int ctrl_averaging_count_lsb   = 5;  // averaging_count, 2 bits
    localparam int ctrl_diff_bit   = 7;  // differential mode
    localparam int ctrl_conv_bit   = 8;  // start a conversion (self clears)
    // status register field positions
    localparam int stat_done_bit   = 0;  // conversion_done_flag
    localparam int stat_fail_bit   = 1;  // selftrim_fail_flag
    localparam int stat_busy_bit   = 2;  // calibration running
    // reset values
    localparam logic [15:0] gain_reset   = 16'h8310;
    localparam logic [15:0] offset_reset = 16'h0000;
    // timing: longest calibration
    localparam int cal_conv_cycles = 15000;
    localparam int cal_bus_cycles  = 100;
    localparam int clk_mhz         = 100;
    localparam int conv_clk_khz    = 4000; // slowest allowed conversion clk
    localparam int conv_div        = (clk_mhz * 1000) / conv_clk_khz;
    typedef enum {adcsc_idle_type_s, adcsc_run_s, adcsc_fin_s} adcsc_st_type;
endpackage : adcsc_pkg
`default_nettype wire

// File: src/adcsc_top.sv
// self calibration control and register file of the 16-bit converter
`default_nettype none
module adcsc_top #(
    parameter int cal_cycles = adcsc_pkg::cal_conv_cycles
        * adcsc_pkg::conv_div + adcsc_pkg::cal_bus_cycles
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        stop_mode,
    output logic             calibrating
);
    // refuse a budget that the run counter cannot serve
    if (cal_cycles < 2) begin : g_bad_cal
        $error("cal_cycles out of range");
    end

    localparam int cw = $clog2(cal_cycles + 1);

    // stop request comes from outside: two flops before use
    logic stop_s1_q;
    logic stop_s2_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stop_s1_q <= 1'b0;
            stop_s2_q <= 1'b0;
        end else begin
            stop_s1_q <= stop_mode;
            stop_s2_q <= stop_s1_q;
        end
    end

    // decode a word address to a trim slot, -1 when none
    function automatic int trim_slot(input logic [7:0] a,
                                     input logic [7:0] base);
        int k;
        trim_slot = -1;
        for (k = 0; k < adcsc_pkg::trim_count; k++) begin
            if (a == 8'(base + 8'(4 * k))) begin
                trim_slot = k;
            end
        end
    endfunction : trim_slot

    logic [8:0]  ctrl_q, ctrl_d;
    logic        done_q, done_d;
    logic        fail_q, fail_d;
    logic [15:0] off_q, off_d;
    logic [15:0] pg_q, pg_d;
    logic [15:0] mg_q, mg_d;
    logic [15:0] raw_q, raw_d;
    logic [15:0] pt_q [adcsc_pkg::trim_count];
    logic [15:0] pt_d [adcsc_pkg::trim_count];
    logic [15:0] mt_q [adcsc_pkg::trim_count];
    logic [15:0] mt_d [adcsc_pkg::trim_count];
    logic [cw-1:0] cnt_q, cnt_d;
    adcsc_pkg::adcsc_st_type st_q, st_d;
    logic        ack_q, ack_d;
    logic [31:0] rd_q, rd_d;
    logic        cal_prev_q;
    logic        busy_q;
    logic        conv_go_q, conv_go_d;
    logic [15:0] comp_res;
    logic        comp_valid;

    logic req;
    logic wr;
    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr  = req & wb_we_i;

    // compensation path used by every conversion
    adcsc_comp u_comp (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .go       (conv_go_q),
        .raw      (raw_q),
        .negative (ctrl_q[adcsc_pkg::ctrl_diff_bit]),
        .offset   (off_q),
        .pgain    (pg_q),
        .mgain    (mg_q),
        .result   (comp_res),
        .valid    (comp_valid)
    );

    // register writes, calibration sequencer and flags
    always_comb begin
        int s;
        logic cal_rise;
        logic bad;
        s = -1;
        cal_rise = 1'b0;
        ctrl_d = ctrl_q;
        done_d = done_q;
        fail_d = fail_q;
        off_d = off_q;
        pg_d = pg_q;
        mg_d = mg_q;
        raw_d = raw_q;
        pt_d = pt_q;
        mt_d = mt_q;
        cnt_d = cnt_q;
        st_d = st_q;
        conv_go_d = 1'b0;
        bad = 1'b0;
        if (wr && st_q != adcsc_pkg::adcsc_run_s) begin
            case (wb_adr_i)
                adcsc_pkg::ctrl_off: begin
                    if (wb_sel_i[0]) ctrl_d[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) ctrl_d[8] = wb_dat_i[8];
                end
                adcsc_pkg::offset_off: begin
                    if (wb_sel_i[0]) off_d[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) off_d[15:8] = wb_dat_i[15:8];
                end
                adcsc_pkg::pgain_off: begin
                    if (wb_sel_i[0]) pg_d[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) pg_d[15:8] = wb_dat_i[15:8];
                end
                adcsc_pkg::mgain_off: begin
                    if (wb_sel_i[0]) mg_d[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) mg_d[15:8] = wb_dat_i[15:8];
                end
                adcsc_pkg::raw_off: begin
                    if (wb_sel_i[0]) raw_d[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) raw_d[15:8] = wb_dat_i[15:8];
                end
                default: begin
                    s = trim_slot(wb_adr_i, adcsc_pkg::ptrim_off);
                    if (s >= 0) pt_d[s] = wb_dat_i[15:0];
                    s = trim_slot(wb_adr_i, adcsc_pkg::mtrim_off);
                    if (s >= 0) mt_d[s] = wb_dat_i[15:0];
                end
            endcase
        end
        // conversion start bit is a self clearing strobe
        if (ctrl_d[adcsc_pkg::ctrl_conv_bit]) begin
            conv_go_d = 1'b1;
            ctrl_d[adcsc_pkg::ctrl_conv_bit] = 1'b0;
        end
        cal_rise = ctrl_q[adcsc_pkg::ctrl_cal_bit] & ~cal_prev_q;
        case (st_q)
            adcsc_pkg::adcsc_idle_type_s: begin
                if (cal_rise) begin
                    done_d = 1'b0;
                    fail_d = 1'b0;
                    if (ctrl_q[adcsc_pkg::ctrl_trig_bit]) begin
                        fail_d = 1'b1;
                        ctrl_d[adcsc_pkg::ctrl_cal_bit] = 1'b0;
                    end else begin
                        // mode bits play no part in the sequence
                        cnt_d = cw'(cal_cycles - 1);
                        st_d = adcsc_pkg::adcsc_run_s;
                    end
                end
            end
            adcsc_pkg::adcsc_run_s: begin
                bad = wr | stop_s2_q;
                if (bad) begin
                    fail_d = 1'b1;
                    ctrl_d[adcsc_pkg::ctrl_cal_bit] = 1'b0;
                    st_d = adcsc_pkg::adcsc_idle_type_s;
                end else if (cnt_q == '0) begin
                    st_d = adcsc_pkg::adcsc_fin_s;
                end else begin
                    cnt_d = cnt_q - cw'(1);
                end
            end
            adcsc_pkg::adcsc_fin_s: begin
                done_d = 1'b1;
                off_d = adcsc_pkg::offset_reset;
                st_d = adcsc_pkg::adcsc_idle_type_s;
            end
            default: st_d = adcsc_pkg::adcsc_idle_type_s;
        endcase
        // a finished conversion wins over a start clearing the flag
        if (comp_valid) done_d = 1'b1;
    end

    // bus answer: one cycle after request, dropped the next
    always_comb begin
        int s;
        s = -1;
        ack_d = req;
        rd_d = 32'h00000000;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                adcsc_pkg::ctrl_off: rd_d = 32'(ctrl_q);
                adcsc_pkg::stat_off: rd_d = 32'({busy_q, fail_q, done_q});
                adcsc_pkg::offset_off: rd_d = 32'(off_q);
                adcsc_pkg::pgain_off: rd_d = 32'(pg_q);
                adcsc_pkg::mgain_off: rd_d = 32'(mg_q);
                adcsc_pkg::result_off: rd_d = 32'(comp_res);
                adcsc_pkg::raw_off: rd_d = 32'(raw_q);
                default: begin
                    s = trim_slot(wb_adr_i, adcsc_pkg::ptrim_off);
                    if (s >= 0) rd_d = 32'(pt_q[s]);
                    s = trim_slot(wb_adr_i, adcsc_pkg::mtrim_off);
                    if (s >= 0) rd_d = 32'(mt_q[s]);
                end
            endcase
        end
    end

    // state registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q     <= 9'h000;
            done_q     <= 1'b0;
            fail_q     <= 1'b0;
            off_q      <= adcsc_pkg::offset_reset;
            pg_q       <= adcsc_pkg::gain_reset;
            mg_q       <= adcsc_pkg::gain_reset;
            raw_q      <= 16'h0000;
            pt_q       <= '{default: 16'h0000};
            mt_q       <= '{default: 16'h0000};
            cnt_q      <= '0;
            st_q       <= adcsc_pkg::adcsc_idle_type_s;
            ack_q      <= 1'b0;
            rd_q       <= 32'h00000000;
            cal_prev_q <= 1'b0;
            busy_q     <= 1'b0;
            conv_go_q  <= 1'b0;
        end else begin
            ctrl_q     <= ctrl_d;
            done_q     <= done_d;
            fail_q     <= fail_d;
            off_q      <= off_d;
            pg_q       <= pg_d;
            mg_q       <= mg_d;
            raw_q      <= raw_d;
            pt_q       <= pt_d;
            mt_q       <= mt_d;
            cnt_q      <= cnt_d;
            st_q       <= st_d;
            ack_q      <= ack_d;
            rd_q       <= rd_d;
            cal_prev_q <= ctrl_q[adcsc_pkg::ctrl_cal_bit];
            busy_q     <= (st_d == adcsc_pkg::adcsc_run_s);
            conv_go_q  <= conv_go_d;
        end
    end

    assign wb_ack_o    = ack_q;
    assign wb_dat_o    = rd_q;
    assign calibrating = busy_q;
endmodule : adcsc_top
`default_nettype wire
